// ==== src/rx_tuning_regs.svh ====
`ifndef RX_TUNING_REGS_SVH
`define RX_TUNING_REGS_SVH

// register indices; byte address is four times the index
`define IDX_OFFSET_MID      6'h22
`define IDX_OFFSET_LOW      6'h23
`define IDX_GAIN_HIGH       6'h24
`define IDX_GAIN_LOW        6'h25
`define IDX_STRENGTH        6'h26
`define IDX_THRESHOLD       6'h27
`define IDX_ANT_ONE         6'h28
`define IDX_ANT_TWO         6'h29
`define IDX_LIMITER         6'h2a
`define IDX_CORR_HIGH       6'h2b
`define IDX_ONOFF_CTRL      6'h2c
`define IDX_ONOFF_LOW       6'h2d
`define IDX_PEAK_HOLDER     6'h2e
`define IDX_EVENT_STATUS    6'h3e
`define IDX_EVENT_MASK      6'h3f

// reset values
`define RST_OFFSET_MID      8'h47
`define RST_OFFSET_LOW      8'hae
`define RST_GAIN_HIGH       3'h2
`define RST_GAIN_LOW        8'h00
`define RST_BYTE_ZERO       8'h00
`define RST_THRESHOLD       8'h1e
`define RST_LIMITER         8'h2a
`define RST_ONOFF_CTRL      6'h2c
`define RST_ONOFF_LOW       8'h00
`define RST_PEAK_HOLDER     7'h2e
`define RST_CORR            10'h000
`define RST_EVENTS          3'h0

// field positions
`define MANCH_BIT           1
`define CTRL_FREEZE_BIT     5
`define CTRL_PEAK_BIT       4
`define CTRL_AVG_BIT        3

// event status bits
`define EV_CLEAR_CHANNEL    0
`define EV_CORR_UPDATED     1
`define EV_PREAMBLE         2
`define EV_COUNT            3

`endif

// ==== src/rx_tuning_pkg.sv ====
package rx_tuning_pkg;

    // measurements and strobes from the demodulator
    typedef struct packed {
        logic [7:0] rssi;
        logic       rssi_strobe;
        logic       ant_one_strobe;
        logic       ant_two_strobe;
        logic       sync_found;
        logic [9:0] corr;
        logic       preamble_det;
    } demod_in_type;

    // settings driven into the demodulator
    typedef struct packed {
        logic [19:0] ncoff;
        logic [10:0] crgain;
        logic [10:0] loop_gain;
        logic [7:0]  threshold;
        logic [7:0]  limiter;
        logic [10:0] onoff_count;
        logic        manchester;
        logic        agc_freeze;
        logic        peak_det_en;
        logic        avg_en;
        logic [2:0]  attack;
        logic [3:0]  decay;
    } tuning_cfg_type;

endpackage : rx_tuning_pkg

// ==== src/bcr_gain_gearshift.sv ====
`timescale 1ns/1ps
`include "rx_tuning_regs.svh"

module bcr_gain_gearshift
(
    // clock and reset
    input  wire logic        clock,
    input  wire logic        rst_b,
    // programmed gain and gearshift
    input  wire logic [10:0] crgain,
    input  wire logic [2:0]  crfast,
    input  wire logic [2:0]  crslow,
    input  wire logic        preamble_det,
    // effective loop gain
    output logic      [10:0] loop_gain
);

    logic [10:0] loop_gain_ff;
    logic [10:0] nxt_loop_gain;

    // fast divisor until preamble, slow divisor after
    always_comb
    begin
        if (preamble_det)
            nxt_loop_gain = crgain >> crslow;
        else
            nxt_loop_gain = crgain >> crfast;
    end

    // registered gain
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
            loop_gain_ff <= 11'h000;
        else
            loop_gain_ff <= nxt_loop_gain;
    end

    assign loop_gain = loop_gain_ff;

    // one cycle after each sampled edge, loop_gain holds crgain shifted by the divisor then selected
    AST_GEAR_SLOW: assert property (
        @(posedge clock) disable iff (!rst_b)
        rst_b && preamble_det
        |=> loop_gain == ($past(crgain) >> $past(crslow)))
        else $error("slow gearshift gain wrong");
    AST_GEAR_FAST: assert property (
        @(posedge clock) disable iff (!rst_b)
        rst_b && !preamble_det
        |=> loop_gain == ($past(crgain) >> $past(crfast)))
        else $error("fast gearshift gain wrong");

endmodule : bcr_gain_gearshift

// ==== src/rx_tuning_bank.sv ====
// Added by the designer: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "rx_tuning_regs.svh"

module rx_tuning_bank
(
    // clock and reset
    input  wire logic                        CLOCK,
    input  wire logic                        RST_B,
    // avalon-mm slave
    input  wire logic [7:0]                  AVS_ADDRESS,
    input  wire logic                        AVS_READ,
    input  wire logic                        AVS_WRITE,
    input  wire logic [31:0]                 AVS_WRITEDATA,
    input  wire logic [3:0]                  AVS_BYTEENABLE,
    output logic      [31:0]                 AVS_READDATA,
    output logic                             AVS_WAITREQUEST,
    // neighbouring register fields
    input  wire logic [3:0]                  OFFSET_TOP,
    input  wire logic [2:0]                  GEAR_FAST,
    input  wire logic [2:0]                  GEAR_SLOW,
    input  wire logic [7:0]                  MANCH_REG,
    // demodulator side
    input  wire rx_tuning_pkg::demod_in_type DEMOD,
    output rx_tuning_pkg::tuning_cfg_type    CFG,
    output logic                             CLEAR_CHANNEL,
    // interrupt
    output logic                             IRQ
);

    logic [7:0]  offset_mid_ff;
    logic [7:0]  offset_low_ff;
    logic [2:0]  gain_high_ff;
    logic [7:0]  gain_low_ff;
    logic [7:0]  strength_ff;
    logic [7:0]  threshold_ff;
    logic [7:0]  ant_one_ff;
    logic [7:0]  ant_two_ff;
    logic [7:0]  limiter_ff;
    logic [9:0]  corr_ff;
    logic [5:0]  onoff_ctrl_ff;
    logic [7:0]  onoff_low_ff;
    logic [6:0]  peak_holder_ff;
    logic [2:0]  status_ff;
    logic [2:0]  mask_ff;
    logic        ack_ff;
    logic [7:0]  rdata_ff;
    logic        above_ff;
    logic        preamble_ff;
    logic [7:0]  nxt_rdata;
    logic [2:0]  event_set;
    logic [2:0]  event_clr;
    logic        wr_go;
    logic        rd_go;
    logic        wr_byte;
    logic [5:0]  idx;
    logic [7:0]  wbyte;
    logic [10:0] loop_gain;

    // word index decode, shared by reads and writes
    function automatic logic index_hit(input logic [5:0] a,
                                       input logic [5:0] b);
        index_hit = (a == b);
    endfunction : index_hit

    // one wait state: request seen, then answered
    assign idx             = AVS_ADDRESS[7:2];
    assign wbyte           = AVS_WRITEDATA[7:0];
    assign AVS_WAITREQUEST = (AVS_READ | AVS_WRITE) & ~ack_ff;
    assign wr_go           = AVS_WRITE & ack_ff;
    assign rd_go           = AVS_READ & ack_ff;
    assign wr_byte         = wr_go & AVS_BYTEENABLE[0];
    assign AVS_READDATA    = {24'h000000, rdata_ff};

    // handshake state
    always_ff @(posedge CLOCK or negedge RST_B)
    begin
        if (!RST_B)
            ack_ff <= 1'b0;
        else
            ack_ff <= (AVS_READ | AVS_WRITE) & ~ack_ff;
    end

    // read multiplexer; unmapped indices read zero
    always_comb
    begin
        nxt_rdata = 8'h00;
        if (index_hit(idx, `IDX_OFFSET_MID))
            nxt_rdata = offset_mid_ff;
        if (index_hit(idx, `IDX_OFFSET_LOW))
            nxt_rdata = offset_low_ff;
        if (index_hit(idx, `IDX_GAIN_HIGH))
            nxt_rdata = {5'h00, gain_high_ff};
        if (index_hit(idx, `IDX_GAIN_LOW))
            nxt_rdata = gain_low_ff;
        if (index_hit(idx, `IDX_STRENGTH))
            nxt_rdata = strength_ff;
        if (index_hit(idx, `IDX_THRESHOLD))
            nxt_rdata = threshold_ff;
        if (index_hit(idx, `IDX_ANT_ONE))
            nxt_rdata = ant_one_ff;
        if (index_hit(idx, `IDX_ANT_TWO))
            nxt_rdata = ant_two_ff;
        if (index_hit(idx, `IDX_LIMITER))
            nxt_rdata = limiter_ff;
        if (index_hit(idx, `IDX_CORR_HIGH))
            nxt_rdata = corr_ff[9:2];
        if (index_hit(idx, `IDX_ONOFF_CTRL))
            nxt_rdata = {corr_ff[1:0], onoff_ctrl_ff};
        if (index_hit(idx, `IDX_ONOFF_LOW))
            nxt_rdata = onoff_low_ff;
        if (index_hit(idx, `IDX_PEAK_HOLDER))
            nxt_rdata = {1'b0, peak_holder_ff};
        if (index_hit(idx, `IDX_EVENT_STATUS))
            nxt_rdata = {5'h00, status_ff};
        if (index_hit(idx, `IDX_EVENT_MASK))
            nxt_rdata = {5'h00, mask_ff};
    end

    // read data captured when the request is first seen
    always_ff @(posedge CLOCK or negedge RST_B)
    begin
        if (!RST_B)
            rdata_ff <= `RST_BYTE_ZERO;
        else if (AVS_READ & ~ack_ff)
            rdata_ff <= nxt_rdata;
    end

    // clock recovery offset bytes
    always_ff @(posedge CLOCK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            offset_mid_ff <= `RST_OFFSET_MID;
            offset_low_ff <= `RST_OFFSET_LOW;
        end
        else if (wr_byte)
        begin
            if (index_hit(idx, `IDX_OFFSET_MID))
                offset_mid_ff <= wbyte;
            if (index_hit(idx, `IDX_OFFSET_LOW))
                offset_low_ff <= wbyte;
        end
    end

    // timing loop gain; reserved bits 7:3 not stored
    always_ff @(posedge CLOCK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            gain_high_ff <= `RST_GAIN_HIGH;
            gain_low_ff  <= `RST_GAIN_LOW;
        end
        else if (wr_byte)
        begin
            if (index_hit(idx, `IDX_GAIN_HIGH))
                gain_high_ff <= wbyte[2:0];
            if (index_hit(idx, `IDX_GAIN_LOW))
                gain_low_ff <= wbyte;
        end
    end

    // threshold and limiter
    always_ff @(posedge CLOCK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            threshold_ff <= `RST_THRESHOLD;
            limiter_ff   <= `RST_LIMITER;
        end
        else if (wr_byte)
        begin
            if (index_hit(idx, `IDX_THRESHOLD))
                threshold_ff <= wbyte;
            if (index_hit(idx, `IDX_LIMITER))
                limiter_ff <= wbyte;
        end
    end

    // on-off counter, control bits and peak holder
    always_ff @(posedge CLOCK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            onoff_ctrl_ff  <= `RST_ONOFF_CTRL;
            onoff_low_ff   <= `RST_ONOFF_LOW;
            peak_holder_ff <= `RST_PEAK_HOLDER;
        end
        else if (wr_byte)
        begin
            if (index_hit(idx, `IDX_ONOFF_CTRL))
                onoff_ctrl_ff <= wbyte[5:0];
            if (index_hit(idx, `IDX_ONOFF_LOW))
                onoff_low_ff <= wbyte;
            if (index_hit(idx, `IDX_PEAK_HOLDER))
                peak_holder_ff <= wbyte[6:0];
        end
    end

    // measured strength, only the demodulator writes it
    always_ff @(posedge CLOCK or negedge RST_B)
    begin
        if (!RST_B)
            strength_ff <= `RST_BYTE_ZERO;
        else if (DEMOD.rssi_strobe)
            strength_ff <= DEMOD.rssi;
    end

    // per-antenna captures
    always_ff @(posedge CLOCK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            ant_one_ff <= `RST_BYTE_ZERO;
            ant_two_ff <= `RST_BYTE_ZERO;
        end
        else
        begin
            if (DEMOD.ant_one_strobe)
                ant_one_ff <= DEMOD.rssi;
            if (DEMOD.ant_two_strobe)
                ant_two_ff <= DEMOD.rssi;
        end
    end

    // correction result, taken at every sync
    always_ff @(posedge CLOCK or negedge RST_B)
    begin
        if (!RST_B)
            corr_ff <= `RST_CORR;
        else if (DEMOD.sync_found)
            corr_ff <= DEMOD.corr;
    end

    // clear-channel level and preamble edge tracking
    always_ff @(posedge CLOCK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            above_ff    <= 1'b0;
            preamble_ff <= 1'b0;
        end
        else
        begin
            if (DEMOD.rssi_strobe)
                above_ff <= (DEMOD.rssi > threshold_ff);
            preamble_ff <= DEMOD.preamble_det;
        end
    end

    // event sources
    assign event_set[`EV_CLEAR_CHANNEL] = DEMOD.rssi_strobe
                                        & (DEMOD.rssi > threshold_ff);
    assign event_set[`EV_CORR_UPDATED]  = DEMOD.sync_found;
    assign event_set[`EV_PREAMBLE]      = DEMOD.preamble_det & ~preamble_ff;

    // read of status clears only the bits it reported
    assign event_clr = (rd_go & index_hit(idx, `IDX_EVENT_STATUS))
                     ? rdata_ff[2:0] : 3'h0;

    // sticky status, set wins over clear
    genvar gi;
    generate
        for (gi = 0; gi < `EV_COUNT; gi = gi + 1)
        begin : g_status
            always_ff @(posedge CLOCK or negedge RST_B)
            begin
                if (!RST_B)
                    status_ff[gi] <= 1'b0;
                else
                    status_ff[gi] <= event_set[gi]
                                   | (status_ff[gi] & ~event_clr[gi]);
            end
        end
    endgenerate

    // interrupt mask
    always_ff @(posedge CLOCK or negedge RST_B)
    begin
        if (!RST_B)
            mask_ff <= `RST_EVENTS;
        else if (wr_byte & index_hit(idx, `IDX_EVENT_MASK))
            mask_ff <= wbyte[2:0];
    end

    assign IRQ           = |(status_ff & mask_ff);
    assign CLEAR_CHANNEL = above_ff;

    // gain after gearshift
    bcr_gain_gearshift u_gear
    (
        .clock        (CLOCK),
        .rst_b        (RST_B),
        .crgain       ({gain_high_ff, gain_low_ff}),
        .crfast       (GEAR_FAST),
        .crslow       (GEAR_SLOW),
        .preamble_det (DEMOD.preamble_det),
        .loop_gain    (loop_gain)
    );

    // settings to the demodulator
    always_comb
    begin
        CFG             = '0;
        CFG.ncoff       = {OFFSET_TOP, offset_mid_ff, offset_low_ff};
        CFG.crgain      = {gain_high_ff, gain_low_ff};
        CFG.loop_gain   = loop_gain;
        CFG.threshold   = threshold_ff;
        CFG.limiter     = limiter_ff;
        CFG.onoff_count = {onoff_ctrl_ff[2:0], onoff_low_ff};
        CFG.manchester  = MANCH_REG[`MANCH_BIT];
        CFG.agc_freeze  = onoff_ctrl_ff[`CTRL_FREEZE_BIT];
        CFG.peak_det_en = onoff_ctrl_ff[`CTRL_PEAK_BIT];
        CFG.avg_en      = onoff_ctrl_ff[`CTRL_AVG_BIT];
        CFG.attack      = peak_holder_ff[6:4];
        CFG.decay       = peak_holder_ff[3:0];
    end

    // checks
    default clocking cb @(posedge CLOCK);
    endclocking
    default disable iff (!RST_B);

    AST_OFFSET_WRITE: assert property (
        wr_byte && index_hit(idx, `IDX_OFFSET_LOW)
        |=> CFG.ncoff[7:0] == $past(wbyte))
        else $error("offset low byte not written");
    AST_OFFSET_TOP: assert property (
        CFG.ncoff[19:16] == OFFSET_TOP)
        else $error("offset top nibble wrong");
    AST_GAIN_HIGH: assert property (
        wr_byte && index_hit(idx, `IDX_GAIN_HIGH)
        |=> CFG.crgain[10:8] == $past(wbyte[2:0]))
        else $error("gain high bits not written");
    AST_STRENGTH: assert property (
        DEMOD.rssi_strobe |=> strength_ff == $past(DEMOD.rssi))
        else $error("strength not captured");
    AST_CLEAR_EVENT: assert property (
        event_set[`EV_CLEAR_CHANNEL] |=> status_ff[`EV_CLEAR_CHANNEL]
        ##0 CLEAR_CHANNEL)
        else $error("clear-channel event lost");
    AST_ANT_TWO: assert property (
        DEMOD.ant_two_strobe |=> ant_two_ff == $past(DEMOD.rssi))
        else $error("antenna two not captured");
    AST_LIMITER: assert property (
        wr_byte && index_hit(idx, `IDX_LIMITER)
        |=> CFG.limiter == $past(wbyte))
        else $error("limiter not written");
    AST_CORR_HOLD: assert property (
        !DEMOD.sync_found |=> $stable(corr_ff))
        else $error("correction changed without sync");
    AST_ONOFF_CTRL: assert property (
        wr_byte && index_hit(idx, `IDX_ONOFF_CTRL)
        |=> CFG.agc_freeze == $past(wbyte[5])
            && CFG.peak_det_en == $past(wbyte[4])
            && CFG.avg_en == $past(wbyte[3]))
        else $error("on-off control bits wrong");
    AST_MANCH: assert property (
        CFG.manchester == MANCH_REG[1])
        else $error("manchester flag wrong");
    AST_RO_WRITE: assert property (
        wr_go && index_hit(idx, `IDX_STRENGTH) && !DEMOD.rssi_strobe
        |=> $stable(strength_ff))
        else $error("read-only strength written");
    AST_WAIT_ONE: assert property (
        (AVS_READ || AVS_WRITE) && !ack_ff |-> AVS_WAITREQUEST ##1 !ack_ff
        || !AVS_WAITREQUEST)
        else $error("waitrequest not released");

    COV_READ_STATUS: cover property (
        rd_go && index_hit(idx, `IDX_EVENT_STATUS) && rdata_ff != 8'h00);
    COV_IRQ: cover property (IRQ ##1 !IRQ);
    COV_SET_CLEAR: cover property (
        event_set[`EV_CLEAR_CHANNEL] && event_clr[`EV_CLEAR_CHANNEL]);

endmodule : rx_tuning_bank

// ==== sim/host_cfg_model.sv ====
`timescale 1ns/1ps

module host_cfg_model
#(
    parameter int RATE_KBPS = 40,
    parameter int DEV_KHZ   = 80,
    parameter int OSR_X8    = 200,
    parameter int DEC_EXP   = 0,
    parameter int DEC_BYP   = 0
)
(
    // manchester flag in use
    input  wire logic        manch,
    // settings the host programs
    output logic      [19:0] offset_val,
    output logic      [10:0] gain_val,
    output logic      [10:0] count_val
);
    // host-side arithmetic for the tuning values
    always_comb
    begin
        longint m;
        m = longint'(manch);
        offset_val = 20'(RATE_KBPS * (1 + m) * (64'd1 << (20 + DEC_EXP))
                     / (500 * (1 + 2 * DEC_BYP)));
        gain_val   = 11'(2 + (32768 * RATE_KBPS * (1 + m) * 8)
                     / (OSR_X8 * DEV_KHZ));
        count_val  = 11'(1500 / (RATE_KBPS * (1 + m)));
    end
endmodule : host_cfg_model

// ==== sim/rx_tuning_bank_bench.sv ====
`timescale 1ns/1ps
`include "rx_tuning_regs.svh"

`define CHECK(got, exp) \
    begin \
        n_compared++; \
        if ((got) !== (exp)) \
        begin \
            n_mismatch++; \
            $display("ERROR %0t: got %h expected %h", $time, got, exp); \
        end \
    end

module rx_tuning_bank_bench;
    // bench signals
    logic                          clock;
    logic                          rst_b;
    logic [7:0]                    address;
    logic                          rd;
    logic                          wr;
    logic [31:0]                   wdata;
    logic [3:0]                    be;
    logic [31:0]                   rdata;
    logic                          waitreq;
    logic [3:0]                    offset_top;
    logic [2:0]                    gear_fast;
    logic [2:0]                    gear_slow;
    logic [7:0]                    manch_reg;
    rx_tuning_pkg::demod_in_type   demod;
    rx_tuning_pkg::tuning_cfg_type cfg;
    logic                          clear_channel;
    logic                          irq;
    logic [19:0]                   offset_val;
    logic [10:0]                   gain_val;
    logic [10:0]                   count_val;
    logic [7:0]                    got;
    int                            n_mismatch;
    int                            n_compared;

    // reset values and writable masks, 22h upward
    localparam logic [7:0] RST_TAB [13] = '{8'h47, 8'hae, 8'h02, 8'h00,
        8'h00, 8'h1e, 8'h00, 8'h00, 8'h2a, 8'h00, 8'h2c, 8'h00, 8'h2e};
    localparam logic [7:0] RW_TAB [13] = '{8'hff, 8'hff, 8'h07, 8'hff,
        8'h00, 8'hff, 8'h00, 8'h00, 8'hff, 8'h00, 8'h3f, 8'hff, 8'h7f};

    rx_tuning_bank uut
    (
        .CLOCK           (clock),
        .RST_B           (rst_b),
        .AVS_ADDRESS     (address),
        .AVS_READ        (rd),
        .AVS_WRITE       (wr),
        .AVS_WRITEDATA   (wdata),
        .AVS_BYTEENABLE  (be),
        .AVS_READDATA    (rdata),
        .AVS_WAITREQUEST (waitreq),
        .OFFSET_TOP      (offset_top),
        .GEAR_FAST       (gear_fast),
        .GEAR_SLOW       (gear_slow),
        .MANCH_REG       (manch_reg),
        .DEMOD           (demod),
        .CFG             (cfg),
        .CLEAR_CHANNEL   (clear_channel),
        .IRQ             (irq)
    );

    host_cfg_model host
    (
        .manch      (manch_reg[1]),
        .offset_val (offset_val),
        .gain_val   (gain_val),
        .count_val  (count_val)
    );

    // free-running clock
    initial clock = 1'b0;
    always #12.5 clock = ~clock;

    // verdict and end of run
    task automatic test_done;
        if (n_mismatch == 0 && n_compared > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : test_done

    // one avalon transfer, held until waitrequest is seen low
    task automatic bus(input logic [5:0] idx, input logic w,
                       input logic [7:0] d);
        @(posedge clock);
        address <= {idx, 2'b00};
        rd      <= ~w;
        wr      <= w;
        wdata   <= {24'h0, d};
        // waitrequest sampled at each rising edge; only the guard ends a hang
        @(posedge clock);
        while (waitreq !== 1'b0)
            @(posedge clock);
        got = rdata[7:0];
        rd <= 1'b0;
        wr <= 1'b0;
        @(negedge clock);
    endtask : bus

    // read a register and compare
    task automatic chk_reg(input logic [5:0] idx, input logic [7:0] exp);
        bus(idx, 1'b0, 8'h00);
        `CHECK(got, exp)
        `CHECK(rdata[31:8], 24'h000000)
    endtask : chk_reg

    // one-cycle demodulator strobe, order rssi, ant one, ant two, sync
    task automatic pulse(input logic [3:0] k, input logic [7:0] r,
                         input logic [9:0] c);
        @(posedge clock);
        demod.rssi <= r;
        demod.corr <= c;
        {demod.rssi_strobe, demod.ant_one_strobe, demod.ant_two_strobe,
         demod.sync_found} <= k;
        @(posedge clock);
        {demod.rssi_strobe, demod.ant_one_strobe, demod.ant_two_strobe,
         demod.sync_found} <= 4'h0;
        @(negedge clock);
    endtask : pulse

    // hang guard
    initial
    begin
        repeat (5000) @(posedge clock);
        n_mismatch++;
        test_done();
    end

    // main sequence
    initial
    begin
        n_mismatch = 0;
        n_compared = 0;
        rst_b      = 1'b0;
        address    = 8'h00;
        rd         = 1'b0;
        wr         = 1'b0;
        wdata      = 32'h0;
        be         = 4'h1;
        offset_top = 4'h1;
        gear_fast  = 3'h1;
        gear_slow  = 3'h5;
        manch_reg  = 8'h00;
        demod      = '0;
        repeat (5) @(posedge clock);
        `CHECK(cfg.ncoff, {4'h1, 8'h47, 8'hae})
        rst_b <= 1'b1;
        // reset values, then write ones to 22h through 2eh and read back
        for (int i = 0; i < 13; i++)
            chk_reg(6'(`IDX_OFFSET_MID + i), RST_TAB[i]);
        chk_reg(`IDX_EVENT_STATUS, 8'h00);
        for (int i = 0; i < 13; i++)
            bus(6'(`IDX_OFFSET_MID + i), 1'b1, 8'hff);
        for (int i = 0; i < 13; i++)
            chk_reg(6'(`IDX_OFFSET_MID + i), RW_TAB[i]);
        `CHECK(cfg.limiter, 8'hff)
        // disabled byte lane and unmapped index
        @(posedge clock);
        be <= 4'h0;
        bus(`IDX_THRESHOLD, 1'b1, 8'h00);
        @(posedge clock);
        be <= 4'h1;
        chk_reg(`IDX_THRESHOLD, 8'hff);
        bus(6'h10, 1'b1, 8'h5a);
        chk_reg(6'h10, 8'h00);
        // host-computed tuning values with manchester on
        @(posedge clock);
        manch_reg  <= 8'h02;
        offset_top <= offset_val[19:16];
        @(posedge clock);
        offset_top <= offset_val[19:16];
        bus(`IDX_OFFSET_MID, 1'b1, offset_val[15:8]);
        bus(`IDX_OFFSET_LOW, 1'b1, offset_val[7:0]);
        bus(`IDX_GAIN_HIGH, 1'b1, {5'h1f, gain_val[10:8]});
        bus(`IDX_GAIN_LOW, 1'b1, gain_val[7:0]);
        bus(`IDX_ONOFF_CTRL, 1'b1, {5'h00, count_val[10:8]});
        bus(`IDX_ONOFF_LOW, 1'b1, count_val[7:0]);
        `CHECK(cfg.ncoff, offset_val)
        `CHECK(cfg.crgain, gain_val)
        `CHECK(cfg.onoff_count, count_val)
        `CHECK(cfg.manchester, 1'b1)
        chk_reg(`IDX_GAIN_HIGH, {5'h00, gain_val[10:8]});
        // each control bit on its own
        for (int i = 0; i < 3; i++)
        begin
            bus(`IDX_ONOFF_CTRL, 1'b1, 8'(8'h08 << i));
            got = {5'h00, cfg.agc_freeze, cfg.peak_det_en, cfg.avg_en};
            `CHECK(got, 8'(1 << i))
        end
        bus(`IDX_PEAK_HOLDER, 1'b1, 8'hda);
        `CHECK({cfg.attack, cfg.decay}, 7'h5a)
        chk_reg(`IDX_PEAK_HOLDER, 8'h5a);
        // gearshift before and after preamble, event masked
        `CHECK(cfg.loop_gain, gain_val >> 1)
        @(posedge clock);
        demod.preamble_det <= 1'b1;
        repeat (2) @(posedge clock);
        @(negedge clock);
        `CHECK(cfg.loop_gain, gain_val >> 5)
        `CHECK(irq, 1'b0)
        chk_reg(`IDX_EVENT_STATUS, 8'h04);
        // clear-channel events around the threshold
        bus(`IDX_EVENT_MASK, 1'b1, 8'h03);
        bus(`IDX_THRESHOLD, 1'b1, 8'h30);
        `CHECK(cfg.threshold, 8'h30)
        pulse(4'b1000, 8'h31, 10'h000);
        `CHECK(clear_channel, 1'b1)
        `CHECK(irq, 1'b1)
        chk_reg(`IDX_STRENGTH, 8'h31);
        chk_reg(`IDX_EVENT_STATUS, 8'h01);
        `CHECK(irq, 1'b0)
        pulse(4'b1000, 8'h30, 10'h000);
        `CHECK(clear_channel, 1'b0)
        `CHECK(irq, 1'b0)
        // antenna captures
        pulse(4'b0100, 8'h11, 10'h000);
        pulse(4'b0010, 8'h22, 10'h000);
        chk_reg(`IDX_ANT_ONE, 8'h11);
        chk_reg(`IDX_ANT_TWO, 8'h22);
        // correction result taken only at sync
        bus(`IDX_ONOFF_CTRL, 1'b1, 8'h00);
        pulse(4'b0001, 8'h00, 10'h2d5);
        `CHECK(irq, 1'b1)
        chk_reg(`IDX_CORR_HIGH, 8'hb5);
        chk_reg(`IDX_ONOFF_CTRL, 8'h40);
        pulse(4'b1000, 8'h00, 10'h3ff);
        chk_reg(`IDX_CORR_HIGH, 8'hb5);
        chk_reg(`IDX_EVENT_STATUS, 8'h02);
        test_done();
    end
endmodule : rx_tuning_bank_bench
